// >>> inc/fhr_pkg.sv
`default_nettype none
package fhr_pkg;
  // Register byte addresses (printed offsets are not word aligned: index * 4)
  localparam logic [9:0] FHR_IDX_DATA = 10'h3f5;
  localparam logic [9:0] FHR_IDX_DIR = 10'h3f7;
  localparam logic [11:0] FHR_ADDR_DATA = {FHR_IDX_DATA, 2'b00};
  localparam logic [11:0] FHR_ADDR_DIR = {FHR_IDX_DIR, 2'b00};
  // Own registers
  localparam logic [11:0] FHR_ADDR_CTRL = 12'h000;
  localparam logic [11:0] FHR_ADDR_STAT = 12'h004;
  localparam logic [11:0] FHR_ADDR_RATE = 12'h008;
  localparam logic [11:0] FHR_ADDR_ST0 = 12'h00c;
  localparam logic [11:0] FHR_ADDR_EXEC = 12'h010;
  localparam logic [11:0] FHR_ADDR_DISK = 12'h014;
  // Field positions
  localparam int FHR_CTRL_SWRST = 0;
  localparam int FHR_CTRL_FIFOEN = 1;
  localparam int FHR_CTRL_DMAGATE = 2;
  localparam int FHR_CTRL_FORCECHG = 3;
  localparam int FHR_CTRL_FORCEVAL = 4;
  localparam int FHR_CTRL_THR_LO = 8;
  localparam int FHR_EXEC_START = 0;
  localparam int FHR_EXEC_WRITE = 1;
  localparam int FHR_EXEC_RESULT = 2;
  localparam int FHR_EXEC_END = 3;
  // Reset values
  localparam logic [1:0] FHR_RATE_500K = 2'h0;
  localparam logic [1:0] FHR_RATE_300K = 2'h1;
  localparam logic [1:0] FHR_RATE_250K = 2'h2;
  localparam logic [1:0] FHR_RATE_1M = 2'h3;
  localparam logic [1:0] FHR_RATE_RST = FHR_RATE_250K;
  localparam logic [3:0] FHR_THR_RST = 4'h0;
  localparam logic [7:0] FHR_FILL_BYTE = 8'h00;
  localparam int FHR_EC_STEPS = 80;
  localparam logic [31:0] FHR_UNMAPPED = 32'h0000_0000;
  // Compatibility layouts
  typedef enum logic [1:0] {
    FHR_MODE_AT = 2'b00,
    FHR_MODE_PS = 2'b01,
    FHR_MODE_M30 = 2'b10
  } fhr_mode_t;
  // Data port phases
  typedef enum logic [1:0] {
    FHR_PH_CMD = 2'b00,
    FHR_PH_EXEC = 2'b01,
    FHR_PH_RESULT = 2'b10,
    FHR_PH_DRAIN = 2'b11
  } fhr_phase_t;
  // Termination codes
  localparam logic [1:0] FHR_TC_NORMAL = 2'b00;
  localparam logic [1:0] FHR_TC_ABNORMAL = 2'b01;
  localparam logic [1:0] FHR_TC_INVALID = 2'b10;
  localparam logic [1:0] FHR_TC_POLL = 2'b11;
endpackage : fhr_pkg
`default_nettype wire

// >>> rtl/fhr_regs.sv
// Contract
// RULE1 - One data port carries all bytes
// RULE2 - FIFO disabled after every reset
// RULE3 - Configuration enables FIFO with threshold
// RULE4 - Parameters bypass FIFO, host obeys ready
// RULE5 - FIFO flushed entering execution phase
// RULE6 - Overrun or underrun aborts command
// RULE7 - Underrun write pads zeros then CRC
// RULE8 - Host drains bytes after read overrun
// RULE9 - Host services FIFO within latency budget
// RULE10 - Input register read-only, first layout zeros
// RULE11 - Bit 7 inverted change pin or forced
// RULE12 - Second layout ones, rate, density flag
// RULE13 - Third layout rate, precomp, dma gate
// RULE14 - Rate kept on soft, 250K hard reset
// RULE15 - Config register rate in bits 1:0
// RULE16 - Precomp bit stored, readable, soft-kept
// RULE17 - Density pin high only hardware reset
// RULE18 - Result phase supplies status bytes
// RULE19 - Status 0 bits 7:6 termination code
// RULE20 - Status 0 bit 5 seek done
// RULE21 - Status 0 bit 4 equipment fault
// RULE22 - Bit3 zero, head bit2, unit 1:0
// RULE23 - Access only when ready, direction tells
// RULE24 - Latest rate write wins
// RULE25 - Mode input picks register layout
// RULE26 - Standard rate encoding
`default_nettype none
module fhr_regs #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration
  input wire fhr_pkg::fhr_mode_t compat_mode,
  // Drive cable
  input wire logic media_changed_n,
  input wire logic track_zero_pin,
  // Disk side byte stream
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic disk_byte_take,
  output logic [7:0] disk_wr_byte,
  output logic disk_wr_pad,
  // Drive outputs
  output logic density_pin,
  output logic [1:0] rate_select,
  output logic precomp_off_flag,
  output logic host_transfer_ready,
  output logic transfer_direction,
  output logic cmd_abort
);
  import fhr_pkg::*;

  // ************
  // Synchronisers
  // ************
  logic [1:0] chg_sync;
  logic [1:0] trk_sync;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Pin idles high; resetting to its idle level avoids a false change flag
      chg_sync <= 2'h3;
      trk_sync <= 2'h0;
    end else begin
      chg_sync <= {chg_sync[0], media_changed_n};
      trk_sync <= {trk_sync[0], track_zero_pin};
    end
  end
  wire logic chg_n_s = chg_sync[1];
  wire logic track_zero_pin_s = trk_sync[1];

  // ************
  // Bus decode
  // ************
  // Single-cycle answer: waitrequest low whenever a request is present
  assign avs_waitrequest = 1'b0;
  wire logic wr_ctrl = avs_write && (avs_address == FHR_ADDR_CTRL);
  wire logic wr_rate = avs_write && (avs_address == FHR_ADDR_RATE);
  wire logic wr_ccr = avs_write && (avs_address == FHR_ADDR_DIR);
  wire logic wr_exec = avs_write && (avs_address == FHR_ADDR_EXEC);
  wire logic wr_st0 = avs_write && (avs_address == FHR_ADDR_ST0);
  wire logic wr_data = avs_write && (avs_address == FHR_ADDR_DATA); // [RULE1]
  wire logic rd_data = avs_read && (avs_address == FHR_ADDR_DATA); // [RULE1]

  // ************
  // Control state
  // ************
  logic fifo_en;
  logic [3:0] threshold;
  logic dma_gate;
  logic force_chg;
  logic force_val;
  logic soft_rst;
  logic precomp_bit;
  logic [7:0] status0;
  logic [6:0] step_cnt;
  fhr_phase_t phase;
  logic exec_write;
  wire logic sw_reset = wr_ctrl && avs_writedata[FHR_CTRL_SWRST];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_en <= 1'b0; // [RULE2]
      threshold <= FHR_THR_RST;
      dma_gate <= 1'b0;
      force_chg <= 1'b0;
      force_val <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= sw_reset;
      if (sw_reset) begin
        fifo_en <= 1'b0; // [RULE2]
        threshold <= FHR_THR_RST;
      end else if (wr_ctrl) begin
        fifo_en <= avs_writedata[FHR_CTRL_FIFOEN]; // [RULE3]
        threshold <= avs_writedata[FHR_CTRL_THR_LO +: 4]; // [RULE3]
        dma_gate <= avs_writedata[FHR_CTRL_DMAGATE];
        force_chg <= avs_writedata[FHR_CTRL_FORCECHG];
        force_val <= avs_writedata[FHR_CTRL_FORCEVAL];
      end
    end
  end

  // Rate and precomp survive software reset; only resetn touches them
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rate_select <= FHR_RATE_RST; // [RULE14] [RULE26]
      precomp_bit <= 1'b0;
      density_pin <= 1'b1; // [RULE17]
    end else begin
      if (wr_rate || wr_ccr) begin
        rate_select <= avs_writedata[1:0]; // [RULE15] [RULE24]
        density_pin <= (avs_writedata[1:0] == FHR_RATE_500K) ||
                       (avs_writedata[1:0] == FHR_RATE_1M);
      end
      if (wr_ccr && compat_mode == FHR_MODE_M30) begin
        precomp_bit <= avs_writedata[2]; // [RULE16]
      end
    end
  end
  assign precomp_off_flag = precomp_bit;

  // ************
  // Data FIFO
  // ************
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire logic full = (count == (AW+1)'(DEPTH));
  wire logic empty = (count == '0);
  // Single-byte mode: depth of one
  wire logic eff_full = fifo_en ? full : (count != '0);
  wire logic in_exec = (phase == FHR_PH_EXEC);
  wire logic in_drain = (phase == FHR_PH_DRAIN);
  wire logic enter_exec = wr_exec && avs_writedata[FHR_EXEC_START];
  wire logic push_disk = in_exec && !exec_write && disk_byte_valid && !eff_full;
  wire logic push_host = in_exec && exec_write && wr_data && !eff_full;
  wire logic pop_host = (in_exec || in_drain) && !exec_write && rd_data && !empty;
  wire logic pop_disk = in_exec && exec_write && disk_byte_take && !empty;
  wire logic overrun = push_disk == 1'b0 && in_exec && !exec_write && disk_byte_valid;
  wire logic underrun = in_exec && exec_write && disk_byte_take && empty;
  wire logic push = push_disk || push_host;
  wire logic pop = pop_host || pop_disk;
  wire logic flush = enter_exec || soft_rst; // [RULE5]

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr] <= push_disk ? disk_byte : avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (flush) begin
      wptr <= '0; // [RULE5]
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ************
  // Phase control
  // ************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= FHR_PH_CMD;
      exec_write <= 1'b0;
      cmd_abort <= 1'b0;
      disk_wr_pad <= 1'b0;
    end else if (soft_rst) begin
      phase <= FHR_PH_CMD;
      cmd_abort <= 1'b0;
      disk_wr_pad <= 1'b0;
    end else begin
      case (phase)
        FHR_PH_CMD: begin
          if (enter_exec) begin
            phase <= FHR_PH_EXEC;
            exec_write <= avs_writedata[FHR_EXEC_WRITE];
            cmd_abort <= 1'b0;
            disk_wr_pad <= 1'b0;
          end
        end
        FHR_PH_EXEC: begin
          if (overrun) begin
            cmd_abort <= 1'b1; // [RULE6]
            phase <= FHR_PH_DRAIN; // [RULE8]
          end else if (underrun) begin
            cmd_abort <= 1'b1; // [RULE6]
            disk_wr_pad <= 1'b1; // [RULE7]
            phase <= FHR_PH_RESULT;
          end else if (wr_exec && avs_writedata[FHR_EXEC_END]) begin
            phase <= FHR_PH_RESULT;
          end
        end
        FHR_PH_DRAIN: begin
          if (empty) phase <= FHR_PH_RESULT; // [RULE8]
        end
        FHR_PH_RESULT: begin
          if (wr_exec && avs_writedata[FHR_EXEC_RESULT]) phase <= FHR_PH_CMD;
        end
        default: phase <= FHR_PH_CMD;
      endcase
    end
  end

  // Zeros fill the sector after underrun; CRC is closed by the serializer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) disk_wr_byte <= FHR_FILL_BYTE;
    else if (pop_disk) disk_wr_byte <= mem[rptr];
    else if (underrun || disk_wr_pad) disk_wr_byte <= FHR_FILL_BYTE; // [RULE7]
  end

  // ************
  // Status byte 0
  // ************
  wire logic recal_start = wr_st0 && avs_writedata[8];
  wire logic out_past0 = wr_st0 && avs_writedata[9];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status0 <= 8'h00;
      step_cnt <= 7'h00;
    end else begin
      if (wr_st0) begin
        status0[7:6] <= avs_writedata[7:6]; // [RULE19]
        status0[5] <= avs_writedata[5]; // [RULE20]
        status0[4] <= out_past0; // [RULE21]
        status0[3] <= 1'b0; // [RULE22]
        status0[2:0] <= avs_writedata[2:0]; // [RULE22]
      end
      if (recal_start) step_cnt <= 7'h00;
      else if (wr_st0 && avs_writedata[10] && !track_zero_pin_s) begin
        if (step_cnt == 7'(FHR_EC_STEPS - 1)) status0[4] <= 1'b1; // [RULE21]
        step_cnt <= step_cnt + 7'h01;
      end
    end
  end

  // ************
  // Read mux
  // ************
  wire logic dsk_bit = force_chg ? force_val : !chg_n_s; // [RULE11]
  wire logic low_rate_flag_n = (rate_select == FHR_RATE_250K) ||
                               (rate_select == FHR_RATE_300K); // [RULE12]
  wire logic [7:0] dir_at = {dsk_bit, 7'h00}; // [RULE10]
  wire logic [7:0] dir_ps = {dsk_bit, 4'hf, rate_select, low_rate_flag_n}; // [RULE12]
  wire logic [7:0] dir_m30 = {dsk_bit, 3'h0, dma_gate, precomp_bit, rate_select}; // [RULE13]
  wire logic [7:0] dir_val = (compat_mode == FHR_MODE_PS) ? dir_ps :
                             (compat_mode == FHR_MODE_M30) ? dir_m30 : dir_at; // [RULE25]
  wire logic [7:0] data_val = (phase == FHR_PH_RESULT) ? status0 :
                              (empty ? 8'h00 : mem[rptr]); // [RULE18]
  assign host_transfer_ready = (phase == FHR_PH_CMD) || (phase == FHR_PH_RESULT) ||
                               (exec_write ? !eff_full : !empty); // [RULE23] [RULE4]
  assign transfer_direction = (phase == FHR_PH_RESULT) || in_drain ||
                              (in_exec && !exec_write); // [RULE23]
  wire logic [31:0] next_readdata =
    (avs_address == FHR_ADDR_DIR) ? {24'h0, dir_val} :
    (avs_address == FHR_ADDR_DATA) ? {24'h0, data_val} :
    (avs_address == FHR_ADDR_CTRL) ? {20'h0, threshold, 3'h0, force_val, force_chg,
                                      dma_gate, fifo_en, 1'b0} :
    (avs_address == FHR_ADDR_STAT) ? {23'h0, count[3:0], cmd_abort, phase,
                                      transfer_direction, host_transfer_ready} :
    (avs_address == FHR_ADDR_RATE) ? {29'h0, precomp_bit, rate_select} :
    (avs_address == FHR_ADDR_ST0) ? {24'h0, status0} :
    (avs_address == FHR_ADDR_DISK) ? {30'h0, track_zero_pin_s, !chg_n_s} : FHR_UNMAPPED;
  // Combinational read data: valid in the cycle waitrequest is low
  assign avs_readdata = avs_read ? next_readdata : FHR_UNMAPPED;

  // ************
  // Assertions
  // ************
  sequence s_underrun;
    in_exec && exec_write && disk_byte_take && empty;
  endsequence
  a_fifo_flush: assert property (@(posedge ref_clk) disable iff (!resetn)
    enter_exec |=> count == '0) else $error("FIFO not flushed"); // [RULE5]
  a_abort_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    (overrun || underrun) |=> cmd_abort) else $error("no abort"); // [RULE6]
  a_pad_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_underrun |=> disk_wr_pad && disk_wr_byte == 8'h00) else $error("no pad"); // [RULE7]
  a_at_zeros: assert property (@(posedge ref_clk) disable iff (!resetn)
    (avs_read && avs_address == FHR_ADDR_DIR && compat_mode == FHR_MODE_AT)
    |-> avs_readdata[6:0] == 7'h00) else $error("AT bits nonzero"); // [RULE10]
  a_rate_soft: assert property (@(posedge ref_clk) disable iff (!resetn)
    (sw_reset && !wr_rate && !wr_ccr) |=> $stable(rate_select)) else $error("rate lost"); // [RULE14]
  a_ccr_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_ccr |=> rate_select == $past(avs_writedata[1:0])) else $error("ccr rate"); // [RULE24]
  a_fifo_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    sw_reset |=> !fifo_en) else $error("FIFO on after reset"); // [RULE2]
  a_st0_bit3: assert property (@(posedge ref_clk) disable iff (!resetn)
    status0[3] == 1'b0) else $error("status bit 3 set"); // [RULE22]
  a_ps_ones: assert property (@(posedge ref_clk) disable iff (!resetn)
    (avs_read && avs_address == FHR_ADDR_DIR && compat_mode == FHR_MODE_PS)
    |-> avs_readdata[6:3] == 4'hf) else $error("PS ones"); // [RULE12]
endmodule : fhr_regs
`default_nettype wire

// >>> testbench/fhr_disk_model.sv
`default_nettype none
// ********************
// Drive side model
// ********************
module fhr_disk_model (
  // Clock
  input wire logic ref_clk,
  // Drive cable
  output logic media_changed_n,
  output logic track_zero_pin,
  // Byte stream
  output logic disk_byte_valid,
  output logic [7:0] disk_byte,
  output logic disk_byte_take
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    media_changed_n = 1'b1;
    track_zero_pin = 1'b1;
    disk_byte_valid = 1'b0;
    disk_byte = 8'h5a;
    disk_byte_take = 1'b0;
  end
  task automatic pins(input logic c, input logic t);
    media_changed_n <= c;
    track_zero_pin <= t;
  endtask : pins
  // Idle line shows the inverse so a stale byte never passes as fresh
  task automatic push(input logic [7:0] b, input int gap);
    disk_byte_valid <= 1'b1;
    disk_byte <= b;
    @(posedge ref_clk);
    disk_byte_valid <= 1'b0;
    disk_byte <= ~b;
    repeat (gap) @(posedge ref_clk);
  endtask : push
  task automatic take();
    disk_byte_take <= 1'b1;
    @(posedge ref_clk);
    disk_byte_take <= 1'b0;
    @(posedge ref_clk);
  endtask : take
endmodule : fhr_disk_model
`default_nettype wire

// >>> testbench/tb_floppy_host_data_rate_status_regs.sv
`default_nettype none
module tb_floppy_host_data_rate_status_regs import fhr_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Bench signals
  // ********************
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, disk_wr_pad, density_pin, precomp_off_flag;
  logic host_transfer_ready, transfer_direction, cmd_abort;
  logic [7:0] disk_wr_byte;
  logic [1:0] rate_select;
  fhr_mode_t compat_mode = FHR_MODE_AT;
  wire logic media_changed_n, track_zero_pin, disk_byte_valid, disk_byte_take;
  wire logic [7:0] disk_byte;
  int n_fail = 0;
  int n_compared = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  fhr_regs dut_u (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .compat_mode(compat_mode), .media_changed_n(media_changed_n),
    .track_zero_pin(track_zero_pin), .disk_byte_valid(disk_byte_valid),
    .disk_byte(disk_byte), .disk_byte_take(disk_byte_take), .disk_wr_byte(disk_wr_byte),
    .disk_wr_pad(disk_wr_pad), .density_pin(density_pin), .rate_select(rate_select),
    .precomp_off_flag(precomp_off_flag), .host_transfer_ready(host_transfer_ready),
    .transfer_direction(transfer_direction), .cmd_abort(cmd_abort));
  fhr_disk_model disk_u (.ref_clk(ref_clk), .media_changed_n(media_changed_n),
    .track_zero_pin(track_zero_pin), .disk_byte_valid(disk_byte_valid),
    .disk_byte(disk_byte), .disk_byte_take(disk_byte_take));
  // ********************
  // Tasks
  // ********************
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low; one idle edge keeps strobes clean
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) begin
      n_fail++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(q, e);
  endtask : rchk
  task automatic hw_reset();
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
  endtask : hw_reset
  // ********************
  // Sequence
  // ********************
  initial begin
    hw_reset();
    chk(density_pin, 32'h1);
    chk(rate_select, FHR_RATE_RST);
    rchk(FHR_ADDR_STAT, 32'h1);
    rchk(FHR_ADDR_DIR, 32'h0);
    compat_mode <= FHR_MODE_PS;
    rchk(FHR_ADDR_DIR, 32'h7d);
    compat_mode <= FHR_MODE_M30;
    rchk(FHR_ADDR_DIR, 32'h02);
    $display("test reset done");
    compat_mode <= FHR_MODE_PS;
    for (int r = 0; r < 4; r++) begin
      wr(FHR_ADDR_DIR, r);
      chk(rate_select, r[1:0]);
      chk(density_pin, r == 0 || r == 3);
      rchk(FHR_ADDR_DIR, {25'h0, 4'hf, r[1:0], (r == 1 || r == 2)});
    end
    wr(FHR_ADDR_RATE, 32'h1);
    chk(rate_select, 32'h1);
    wr(FHR_ADDR_DIR, 32'h3);
    chk(rate_select, 32'h3);
    compat_mode <= FHR_MODE_M30;
    wr(FHR_ADDR_DIR, 32'h05);
    wr(FHR_ADDR_CTRL, 32'h04);
    rchk(FHR_ADDR_DIR, 32'h0d);
    chk(precomp_off_flag, 32'h1);
    wr(FHR_ADDR_CTRL, 32'h01);
    rchk(FHR_ADDR_DIR, 32'h0d);
    chk(density_pin, 32'h0);
    hw_reset();
    chk(density_pin, 32'h1);
    rchk(FHR_ADDR_DIR, 32'h02);
    $display("test rate done");
    compat_mode <= FHR_MODE_AT;
    disk_u.pins(1'b0, 1'b1);
    repeat (4) @(posedge ref_clk);
    rchk(FHR_ADDR_DIR, 32'h80);
    wr(FHR_ADDR_CTRL, 32'h08);
    rchk(FHR_ADDR_DIR, 32'h00);
    wr(FHR_ADDR_CTRL, 32'h18);
    rchk(FHR_ADDR_DIR, 32'h80);
    wr(FHR_ADDR_CTRL, 32'h00);
    disk_u.pins(1'b1, 1'b1);
    $display("test change done");
    wr(FHR_ADDR_EXEC, 32'h1);
    disk_u.push(8'h3c, 3);
    rchk(FHR_ADDR_STAT, 32'h27);
    rchk(FHR_ADDR_DATA, 32'h3c);
    wr(FHR_ADDR_ST0, 32'h25);
    wr(FHR_ADDR_EXEC, 32'h8);
    rchk(FHR_ADDR_STAT, 32'h0b);
    rchk(FHR_ADDR_DATA, 32'h25);
    wr(FHR_ADDR_EXEC, 32'h4);
    wr(FHR_ADDR_CTRL, 32'h402);
    wr(FHR_ADDR_EXEC, 32'h1);
    for (int i = 0; i < 3; i++) disk_u.push(8'h10 + i[7:0], i + 1);
    rchk(FHR_ADDR_STAT, 32'h67);
    for (int i = 0; i < 3; i++) rchk(FHR_ADDR_DATA, 32'h10 + i);
    chk(cmd_abort, 32'h0);
    disk_u.push(8'h77, 1);
    disk_u.push(8'h78, 1);
    wr(FHR_ADDR_EXEC, 32'h1);
    rd(FHR_ADDR_STAT);
    chk(q[8:5], 32'h0);
    rchk(FHR_ADDR_DATA, 32'h0);
    wr(FHR_ADDR_CTRL, 32'h01);
    wr(FHR_ADDR_EXEC, 32'h1);
    disk_u.push(8'ha1, 1);
    disk_u.push(8'ha2, 1);
    chk(cmd_abort, 32'h1);
    rd(FHR_ADDR_STAT);
    chk(q[3:2], FHR_PH_DRAIN);
    rchk(FHR_ADDR_DATA, 32'ha1);
    rd(FHR_ADDR_STAT);
    chk(q[3:2], FHR_PH_RESULT);
    wr(FHR_ADDR_EXEC, 32'h4);
    $display("test read done");
    wr(FHR_ADDR_EXEC, 32'h3);
    chk(cmd_abort, 32'h0);
    rd(FHR_ADDR_STAT);
    chk(q[1:0], 32'h1);
    wr(FHR_ADDR_DATA, 32'hc3);
    disk_u.take();
    chk(disk_wr_byte, 32'hc3);
    disk_u.take();
    chk(cmd_abort, 32'h1);
    chk(disk_wr_pad, 32'h1);
    chk(disk_wr_byte, FHR_FILL_BYTE);
    rd(FHR_ADDR_STAT);
    chk(q[3:2], FHR_PH_RESULT);
    wr(FHR_ADDR_EXEC, 32'h4);
    $display("test write done");
    for (int c = 0; c < 4; c++) begin
      wr(FHR_ADDR_ST0, {24'h0, c[1:0], 6'h2d});
      rchk(FHR_ADDR_ST0, {24'h0, c[1:0], 6'h25});
    end
    wr(FHR_ADDR_ST0, 32'h200);
    rd(FHR_ADDR_ST0);
    chk(q[4], 32'h1);
    disk_u.pins(1'b1, 1'b0);
    wr(FHR_ADDR_ST0, 32'h100);
    for (int s = 1; s <= FHR_EC_STEPS; s++) begin
      wr(FHR_ADDR_ST0, 32'h400);
      if (s >= FHR_EC_STEPS - 1) begin
        rd(FHR_ADDR_ST0);
        chk(q[4], s == FHR_EC_STEPS);
      end
    end
    wr(12'h018, 32'hff);
    rchk(12'h018, FHR_UNMAPPED);
    $display("test status done");
    close_out();
  end
endmodule : tb_floppy_host_data_rate_status_regs
`default_nettype wire
